// [src/serial_sound_output_port.v]
`include "sound_port_map.vh"

// Behaviour
// - Serial mode drives bit clock; data valid at its rising edge.
// - Serial mode: shared pin carries serial sample data.
// - Analog mode: shared pin driven high between samples for settling.
// - Serial mode: word select 0 for left, 1 for right.
// - Analog mode: word select shows channel with inverted polarity.
// - Sound system may be clocked from the separate sound clock.
// - Sound system may alternatively be clocked from the reference clock.
module serial_sound_output_port #(
    parameter SAMPLE_BITS = `SAMPLE_BITS,
    parameter HALF_PERIOD = `HALF_PERIOD,
    parameter SETTLE_BITS = `SETTLE_BITS
) (
    input  wire                     clk,
    input  wire                     nrst,
    input  wire                     sound_mode,
    input  wire                     clock_source,
    input  wire                     ref_clock_in,
    input  wire                     sound_clock_in,
    input  wire [2*SAMPLE_BITS-1:0] sample_data,
    input  wire                     sample_valid,
    output wire                     sample_ready,
    output reg                      serial_bit_clock_out,
    output reg                      serial_out_or_settle_strobe,
    output reg                      channel_select_out
);
    localparam CW = 8;
    localparam BW = 6;

    localparam ST_IDLE  = 3'b001;
    localparam ST_SHIFT = 3'b010;
    localparam ST_GAP   = 3'b100;

    wire [2*SAMPLE_BITS-1:0] buf_data;
    wire                     buf_valid;
    reg                      buf_take;

    sample_buffer #(
        .WIDTH (2*SAMPLE_BITS)
    ) u_buf (
        .clk       (clk),
        .nrst      (nrst),
        .in_data   (sample_data),
        .in_valid  (sample_valid),
        .in_ready  (sample_ready),
        .out_data  (buf_data),
        .out_valid (buf_valid),
        .out_ready (buf_take)
    );

    // Both source clocks are foreign: two flops each before use
    reg [1:0] ref_sync_q;
    reg [1:0] snd_sync_q;
    reg       src_last_q;
    wire      src_level;
    wire      src_rise;

    assign src_level = (clock_source == `SRC_SOUND) ? snd_sync_q[1]
                                                    : ref_sync_q[1];
    assign src_rise  = src_level && !src_last_q;

    always @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            ref_sync_q <= 2'b00;
            snd_sync_q <= 2'b00;
            src_last_q <= 1'b0;
        end else begin
            ref_sync_q <= {ref_sync_q[0], ref_clock_in};
            snd_sync_q <= {snd_sync_q[0], sound_clock_in};
            src_last_q <= src_level;
        end
    end

    // Half bit clock ticks counted in source clock edges
    reg [CW-1:0] div_q;
    wire         half_tick;
    assign half_tick = src_rise && (div_q == HALF_PERIOD[CW-1:0] - 8'd1);

    reg [2:0]               state_q;
    reg [BW-1:0]            bit_q;
    reg                     chan_q;
    reg [2*SAMPLE_BITS-1:0] shreg_q;
    wire                    fall_now;

    // Falling edge of the bit clock is when the clock is high at a half tick
    assign fall_now = half_tick && serial_bit_clock_out;

    always @* begin
        buf_take = 1'b0;
        if (fall_now && buf_valid) begin
            if (state_q == ST_IDLE) begin
                buf_take = 1'b1;
            end else if (state_q == ST_SHIFT && chan_q == `WS_RIGHT
                         && bit_q == SAMPLE_BITS[BW-1:0] - 6'd1) begin
                buf_take = (sound_mode == `MODE_SERIAL);
            end else if (state_q == ST_GAP && bit_q == SETTLE_BITS[BW-1:0] - 6'd1) begin
                buf_take = 1'b1;
            end
        end
    end

    always @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            div_q                       <= {CW{1'b0}};
            serial_bit_clock_out        <= `RST_BITCLK;
            state_q                     <= ST_IDLE;
            bit_q                       <= {BW{1'b0}};
            chan_q                      <= `WS_LEFT;
            shreg_q                     <= {2*SAMPLE_BITS{1'b0}};
            serial_out_or_settle_strobe <= 1'b0;
            channel_select_out          <= `RST_SEL;
        end else begin
            if (src_rise) begin
                div_q <= half_tick ? {CW{1'b0}} : div_q + 8'd1;
            end
            if (half_tick) begin
                serial_bit_clock_out <= ~serial_bit_clock_out;
            end
            // All data-side updates happen at the falling edge only
            if (fall_now) begin
                case (state_q)
                    ST_IDLE: begin
                        if (buf_take) begin
                            shreg_q <= buf_data;
                            state_q <= ST_SHIFT;
                            bit_q   <= {BW{1'b0}};
                            chan_q  <= `WS_LEFT;
                        end
                    end
                    ST_SHIFT: begin
                        if (bit_q == SAMPLE_BITS[BW-1:0] - 6'd1) begin
                            bit_q <= {BW{1'b0}};
                            if (chan_q == `WS_LEFT) begin
                                chan_q <= `WS_RIGHT;
                            end else if (buf_take) begin
                                shreg_q <= buf_data;
                                chan_q  <= `WS_LEFT;
                            end else begin
                                state_q <= (sound_mode == `MODE_ANALOG) ? ST_GAP
                                                                        : ST_IDLE;
                            end
                        end else begin
                            bit_q <= bit_q + 6'd1;
                        end
                        if (!(chan_q == `WS_RIGHT
                              && bit_q == SAMPLE_BITS[BW-1:0] - 6'd1 && buf_take)) begin
                            shreg_q <= {shreg_q[2*SAMPLE_BITS-2:0], 1'b0};
                        end
                    end
                    ST_GAP: begin
                        if (bit_q == SETTLE_BITS[BW-1:0] - 6'd1) begin
                            bit_q   <= {BW{1'b0}};
                            if (buf_take) begin
                                shreg_q <= buf_data;
                                chan_q  <= `WS_LEFT;
                                state_q <= ST_SHIFT;
                            end else begin
                                state_q <= ST_IDLE;
                            end
                        end else begin
                            bit_q <= bit_q + 6'd1;
                        end
                    end
                    default: state_q <= ST_IDLE;
                endcase
                if (sound_mode == `MODE_SERIAL) begin
                    // Left word first, MSB first
                    serial_out_or_settle_strobe <= shreg_q[2*SAMPLE_BITS-1];
                    channel_select_out          <= chan_q;
                end else begin
                    // Strobe high whenever no sample is being presented
                    serial_out_or_settle_strobe <= (state_q != ST_SHIFT);
                    channel_select_out          <= ~chan_q;
                end
            end
        end
    end
endmodule

// [src/sound_port_map.vh]
`ifndef SOUND_PORT_MAP_VH
`define SOUND_PORT_MAP_VH

// Sound modes
`define MODE_ANALOG      1'b0
`define MODE_SERIAL      1'b1

// Clock source select
`define SRC_REFERENCE    1'b0
`define SRC_SOUND        1'b1

// Word select encoding in serial mode
`define WS_LEFT          1'b0
`define WS_RIGHT         1'b1

// Sample width and bit clock divider (source clock rising edges per half bit clock)
`define SAMPLE_BITS      16
`define HALF_PERIOD      4

// Settle strobe length in bit clock periods
`define SETTLE_BITS      2

// Reset values
`define RST_SEL          1'b0
`define RST_BITCLK       1'b0

`endif

// [src/sample_buffer.v]
module sample_buffer #(
    parameter WIDTH = 32
) (
    input  wire             clk,
    input  wire             nrst,
    input  wire [WIDTH-1:0] in_data,
    input  wire             in_valid,
    output wire             in_ready,
    output wire [WIDTH-1:0] out_data,
    output wire             out_valid,
    input  wire             out_ready
);
    // Two-entry ring; a stall downstream fills it and drops in_ready
    reg [WIDTH-1:0] mem_q [0:1];
    reg             wr_q;
    reg             rd_q;
    reg [1:0]       cnt_q;
    wire            push;
    wire            pop;

    assign in_ready  = (cnt_q != 2'd2);
    assign out_valid = (cnt_q != 2'd0);
    assign out_data  = mem_q[rd_q];
    assign push      = in_valid && in_ready;
    assign pop       = out_valid && out_ready;

    always @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            wr_q  <= 1'b0;
            rd_q  <= 1'b0;
            cnt_q <= 2'd0;
        end else begin
            if (push) begin
                wr_q <= ~wr_q;
            end
            if (pop) begin
                rd_q <= ~rd_q;
            end
            case ({push, pop})
                2'b10:   cnt_q <= cnt_q + 2'd1;
                2'b01:   cnt_q <= cnt_q - 2'd1;
                default: cnt_q <= cnt_q;
            endcase
        end
    end

    always @(posedge clk) begin
        if (push) begin
            mem_q[wr_q] <= in_data;
        end
    end
endmodule

// [verification/serial_sound_output_port_sva.sv]
module sound_port_sva (
    input logic clk,
    input logic nrst,
    input logic sound_mode,
    input logic clock_source,
    input logic ref_clock_in,
    input logic sound_clock_in,
    input logic serial_bit_clock_out,
    input logic serial_out_or_settle_strobe,
    input logic channel_select_out
);
    wire        bck = serial_bit_clock_out;
    wire        sdo = serial_out_or_settle_strobe;
    wire        ws  = channel_select_out;
    wire        src = clock_source ? sound_clock_in : ref_clock_in;
    logic       src_q;
    logic [5:0] since_q;
    logic       sdo_q;
    logic       shown_q;
    // Set once an analog sample has been shown, so the idle strobe after reset is skipped
    always @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            sdo_q   <= 1'b0;
            shown_q <= 1'b0;
        end else begin
            sdo_q <= sdo;
            if (!sound_mode && sdo_q && !sdo) begin
                shown_q <= 1'b1;
            end
        end
    end
    // Age of the last raw rising edge of the chosen source, saturating
    always @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            src_q   <= 1'b0;
            since_q <= 6'h00;
        end else begin
            src_q   <= src;
            since_q <= (src && !src_q) ? 6'h00 : since_q + {5'h00, since_q != 6'h3f};
        end
    end
    default clocking @(posedge clk); endclocking
    default disable iff (!nrst);
    a_data_on_fall: assert property (sound_mode && $changed(sdo) |-> $fell(bck))
        else $error("data moved off a bit clock fall");
    a_ws_on_fall: assert property (sound_mode && $changed(ws) |-> $fell(bck))
        else $error("word select moved off a bit clock fall");
    a_stable_at_rise: assert property ($rose(bck) |-> $stable(sdo) && $stable(ws))
        else $error("outputs moved at a bit clock rise");
    a_bck_half_hold: assert property ($changed(bck) |=> $stable(bck) [*8])
        else $error("bit clock half period too short");
    a_src_edge_follow: assert property ($changed(bck) |-> since_q < 6'h08)
        else $error("bit clock not led by the chosen source");
    a_settle_hold: assert property (!sound_mode && $rose(sdo) |=> sdo [*8])
        else $error("settle strobe too short");
    a_analog_left: assert property (!sound_mode && $fell(sdo) |-> ws)
        else $error("analog left not shown high");
    a_analog_right: assert property (!sound_mode && $rose(sdo) && shown_q |-> !ws)
        else $error("analog right not shown low");
endmodule

bind serial_sound_output_port sound_port_sva u_sva (.clk(clk), .nrst(nrst),
    .sound_mode(sound_mode), .clock_source(clock_source), .ref_clock_in(ref_clock_in),
    .sound_clock_in(sound_clock_in), .serial_bit_clock_out(serial_bit_clock_out),
    .serial_out_or_settle_strobe(serial_out_or_settle_strobe),
    .channel_select_out(channel_select_out));

// [verification/dac_model.sv]
module dac_model (
    input logic bck,
    input logic sdata,
    input logic ws
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [15:0] sh   = 16'h0000;
    logic        ws_q = 1'b0;
    logic [16:0] got_q[$];
    // Frames by word select edges, so idle bits before a word drop out
    always @(posedge bck) begin
        if (ws !== ws_q) got_q.push_back({ws_q, sh});
        sh   = {sh[14:0], sdata};
        ws_q = ws;
    end
endmodule

// [verification/serial_sound_output_port_tb.sv]
module serial_sound_output_port_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clk = 1'b0, nrst = 1'b0, sound_mode = 1'b1, clock_source = 1'b1;
    logic        ref_clock_in = 1'b0, sound_clock_in = 1'b0;
    logic [31:0] sample_data = 32'h0;
    logic        sample_valid = 1'b0, full = 1'b0, sdo_q = 1'b0;
    wire         sample_ready, bck, sdo, ws;
    int          fails = 0, checks = 0, falls = 0, i;
    logic [16:0] exp_q[$];
    always #2.5 clk = ~clk;
    always #31 ref_clock_in = ~ref_clock_in;
    always #24 sound_clock_in = ~sound_clock_in;
    serial_sound_output_port u_dut (.clk(clk), .nrst(nrst), .sound_mode(sound_mode),
        .clock_source(clock_source), .ref_clock_in(ref_clock_in),
        .sound_clock_in(sound_clock_in), .sample_data(sample_data),
        .sample_valid(sample_valid), .sample_ready(sample_ready),
        .serial_bit_clock_out(bck), .serial_out_or_settle_strobe(sdo),
        .channel_select_out(ws));
    dac_model u_dac (.bck(bck), .sdata(sdo), .ws(ws));
    always @(posedge clk) begin
        sdo_q <= sdo;
        if (nrst && !sound_mode && sdo_q && !sdo) falls <= falls + 1;
    end
    task chk(input logic [31:0] seen, input logic [31:0] want);
        checks++;
        if (seen !== want) begin
            fails++;
            $display("mismatch at %0t: %h vs %h", $time, seen, want);
        end
    endtask
    task end_of_test;
        if (fails == 0 && checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    task rst(input logic m, input logic s);
        @(negedge clk);
        nrst = 1'b0;
        sound_mode = m;
        clock_source = s;
        sample_valid = 1'b0;
        repeat (6) @(negedge clk);
        nrst = 1'b1;
    endtask
    // Valid stays high between words so the buffer fills and refuses
    task send(input logic [31:0] d);
        int n;
        @(negedge clk);
        sample_data = d;
        sample_valid = 1'b1;
        for (n = 0; n < 20000 && sample_ready !== 1'b1; n++) begin
            full = 1'b1;
            @(negedge clk);
        end
        if (n == 20000) begin
            fails++;
            end_of_test;
        end
        @(posedge clk);
        exp_q.push_back({1'b0, d[31:16]});
        exp_q.push_back({1'b1, d[15:0]});
    endtask
    initial begin
        void'($urandom(84765));
        rst(1'b1, 1'b1);
        for (i = 0; i < 5; i++) send($urandom);
        @(negedge clk);
        sample_valid = 1'b0;
        for (i = 0; i < 20000 && u_dac.got_q.size() < 9; i++) @(negedge clk);
        if (i == 20000) begin
            fails++;
            end_of_test;
        end
        chk(u_dac.got_q.size(), 9);
        chk(full, 1'b1);
        chk(ws, 1'b1);
        for (i = 0; i < u_dac.got_q.size(); i++) chk(u_dac.got_q[i], exp_q[i]);
        rst(1'b0, 1'b0);
        for (i = 0; i < 3; i++) send($urandom);
        @(negedge clk);
        sample_valid = 1'b0;
        for (i = 0; i < 20000 && !(falls == 3 && sdo === 1'b1); i++) @(negedge clk);
        if (i == 20000) begin
            fails++;
            end_of_test;
        end
        chk(falls, 3);
        chk(sdo, 1'b1);
        chk(ws, 1'b0);
        end_of_test;
    end
endmodule
